// *** measurement_sequencer_calc_engine.sv ***
// Purpose: conversion sequencer, averaging and calculation engine
// Assumes: AXI4-Lite master, ADC front end on aclk
// Notes: energy and charge are valid in continuous mode only
//
// The address map and the AXI4-Lite register port were decided locally.
`include "meter_cfg.svh"
//
// Contract
// - current, charge after shunt; power, energy after bus
// - power uses latest current and bus
// - zero calibration gives zero power, energy, charge
// - single average updates each result immediately
// - averaging accumulates, then loads averaged results
// - energy and charge accumulate every conversion
// - calculations add no conversion time
// - mode selects shunt, bus, temperature inputs
// - each input has its own conversion time
// - inputs converted in turn; sequence repeats
// - results held until next complete result
// - continuous mode repeats sequence forever
// - triggered mode runs once then shuts down
// - mode write aborts and restarts conversion
// - done flag set after all averaging
// - done clears on flag read, non-shutdown write
// - triggered mode marks accumulations invalid
// - start delay 0 to 510 ms, 2 ms steps
// - register access needs no framing
// - time codes map to 50 to 4120 us
// - one averaging count, 1 to 1024
module measurement_sequencer_calc_engine #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address and data
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // converter front end
  output logic adc_start,
  output logic [1:0] adc_chan,
  input wire logic [19:0] adc_data
);
  meter_pkg::core_state_t q, n;
  logic wr_en, setup_wr, diag_rd, end_conv, seq_end, fin;
  logic cal_zero, acc_valid, cont, rd_ok;
  logic [2:0] mask, new_mask;
  logic [3:0] shift;
  logic [10:0] target;
  logic [31:0] smp, rd_word, fin_sh, fin_bus, fin_tmp;
  logic [31:0] avg_sh, avg_bus, a_cur, a_pwr, b_cur, b_pwr;
  logic texp;

  // byte-lane merge of a write
  function automatic logic [31:0] wmerge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // first enabled input at or after a position
  function automatic logic [1:0] next_chan(input logic [1:0] from,
    input logic [2:0] m);
    logic [1:0] r;
    r = `CHAN_NONE;
    for (int i = 2; i >= 0; i--) begin
      if (m[i] && 2'(i) >= from) begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  // conversion period code to microseconds
  function automatic logic [18:0] ct_us(input logic [2:0] c);
    case (c)
      3'h0: ct_us = 19'(`CT0_US);
      3'h1: ct_us = 19'(`CT1_US);
      3'h2: ct_us = 19'(`CT2_US);
      3'h3: ct_us = 19'(`CT3_US);
      3'h4: ct_us = 19'(`CT4_US);
      3'h5: ct_us = 19'(`CT5_US);
      3'h6: ct_us = 19'(`CT6_US);
      default: ct_us = 19'(`CT7_US);
    endcase
  endfunction

  // period of the input on a channel, from its own field
  function automatic logic [18:0] chan_us(input logic [1:0] ch,
    input logic [31:0] s);
    case (ch)
      `CHAN_SH: chan_us = ct_us(s[`SH_CT_LSB +: 3]);
      `CHAN_BUS: chan_us = ct_us(s[`BUS_CT_LSB +: 3]);
      default: chan_us = ct_us(s[`TMP_CT_LSB +: 3]);
    endcase
  endfunction

  // averaging code to log2 of the count, 1 to 1024
  function automatic logic [3:0] avg_shift(input logic [2:0] c);
    case (c)
      3'h0: avg_shift = 4'h0;
      3'h1: avg_shift = 4'h2;
      3'h2: avg_shift = 4'h4;
      3'h3: avg_shift = 4'h6;
      3'h4: avg_shift = 4'h7;
      3'h5: avg_shift = 4'h8;
      3'h6: avg_shift = 4'h9;
      default: avg_shift = 4'hA;
    endcase
  endfunction

  // decoded controls
  assign mask = q.setup[`MASK_MSB:`MASK_LSB];
  assign new_mask = n.setup[`MASK_MSB:`MASK_LSB];
  assign cont = q.setup[`CONT_BIT];
  assign shift = avg_shift(q.setup[`AVG_LSB +: 3]);
  assign target = 11'h001 << shift;
  assign cal_zero = (q.cal[15:0] == 16'h0000);
  assign acc_valid = cont & ~cal_zero;
  assign wr_en = q.aw_full & q.w_full & ~q.bvalid;
  assign setup_wr = wr_en & (q.awaddr == `REG_SETUP);
  assign diag_rd = arvalid & q.arready & (araddr == `REG_DIAG);

  // conversion end and sequence end
  assign end_conv = (q.state == meter_pkg::seq_conv) & texp & ~q.tload;
  assign seq_end = end_conv &
    (next_chan(q.chan + 2'h1, mask) == `CHAN_NONE);
  assign fin = seq_end & (q.avg_cnt + 11'h001 == target) & ~setup_wr;
  assign smp = {{12{adc_data[19]}}, adc_data};

  // sums including the sample that ends now
  assign fin_sh = q.sum_sh + ((end_conv && q.chan == `CHAN_SH)
                  ? smp : 32'h00000000);
  assign fin_bus = q.sum_bus + ((end_conv && q.chan == `CHAN_BUS)
                   ? smp : 32'h00000000);
  assign fin_tmp = q.sum_tmp + ((end_conv && q.chan == `CHAN_TMP)
                   ? smp : 32'h00000000);
  assign avg_sh = 32'($signed(fin_sh) >>> shift);
  assign avg_bus = 32'($signed(fin_bus) >>> shift);

  // per-sample arithmetic, same cycle as the sample
  calc_unit u_calc_sample (
    .shunt(smp),
    .cur_in(q.inst_cur),
    .bus(smp),
    .cal(q.cal[15:0]),
    .cur_out(a_cur),
    .pwr_out(a_pwr)
  );

  // averaged arithmetic at the end of the last sequence
  calc_unit u_calc_avg (
    .shunt(avg_sh),
    .cur_in(b_cur),
    .bus(avg_bus),
    .cal(q.cal[15:0]),
    .cur_out(b_cur),
    .pwr_out(b_pwr)
  );

  // interval timer for delay and conversion periods
  tick_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(q.tload),
    .load_us(q.tload_us),
    .expired(texp)
  );

  // read decode
  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    case (araddr)
      `REG_CFG: rd_word = q.cfg;
      `REG_SETUP: rd_word = q.setup;
      `REG_CAL: rd_word = q.cal;
      `REG_DIAG: begin
        rd_word[`DIAG_DONE_BIT] = q.done;
        rd_word[`DIAG_VALID_BIT] = acc_valid;
      end
      `REG_SHUNT: rd_word = q.res_sh;
      `REG_BUS: rd_word = q.res_bus;
      `REG_TEMP: rd_word = q.res_tmp;
      `REG_CUR: rd_word = q.cur;
      `REG_PWR: rd_word = q.pwr;
      `REG_ENERGY: rd_word = cal_zero ? 32'h00000000 : q.energy;
      `REG_CHARGE: rd_word = cal_zero ? 32'h00000000 : q.charge;
      default: rd_ok = 1'b0;
    endcase
  end

  // bus slave, sequencer and accumulation
  always_comb begin
    n = q;
    n.adc_start = 1'b0;
    n.tload = 1'b0;
    // address and data taken in either order, no framing needed
    if (awvalid && q.awready) begin
      n.aw_full = 1'b1;
      n.awaddr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_full = 1'b1;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_en) begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = `RESP_OKAY;
      case (q.awaddr)
        `REG_CFG: n.cfg = wmerge(q.cfg, q.wdata, q.wstrb) & `CFG_MASK;
        `REG_SETUP:
          n.setup = wmerge(q.setup, q.wdata, q.wstrb) & `SETUP_MASK;
        `REG_CAL: n.cal = wmerge(q.cal, q.wdata, q.wstrb) & `CAL_MASK;
        default: n.bresp = `RESP_SLVERR;
      endcase
    end
    n.awready = ~n.aw_full & ~n.bvalid;
    n.wready = ~n.w_full & ~n.bvalid;
    // read channel
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_word;
      n.rresp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    n.arready = ~n.rvalid;
    // flag clears
    if (diag_rd || (setup_wr && new_mask != 3'h0)) begin
      n.done = 1'b0;
    end
    // conversion sequencing
    case (q.state)
      meter_pkg::seq_delay: begin
        if (texp && !q.tload) begin
          n.state = meter_pkg::seq_conv;
          n.adc_start = 1'b1;
          n.tload = 1'b1;
          n.tload_us = chan_us(q.chan, q.setup);
        end
      end
      meter_pkg::seq_conv: begin
        if (end_conv) begin
          n.sum_sh = fin_sh;
          n.sum_bus = fin_bus;
          n.sum_tmp = fin_tmp;
          if (q.chan == `CHAN_SH) begin
            n.inst_cur = a_cur;
            if (!cal_zero) begin
              n.charge = q.charge + a_cur;
            end
            if (shift == 4'h0) begin
              n.res_sh = smp;
              n.cur = a_cur;
            end
          end else if (q.chan == `CHAN_BUS) begin
            if (!cal_zero) begin
              n.energy = q.energy + a_pwr;
            end
            if (shift == 4'h0) begin
              n.res_bus = smp;
              n.pwr = a_pwr;
            end
          end else if (shift == 4'h0) begin
            n.res_tmp = smp;
          end
          if (!seq_end) begin
            n.chan = next_chan(q.chan + 2'h1, mask);
            n.adc_start = 1'b1;
            n.tload = 1'b1;
            n.tload_us = chan_us(n.chan, q.setup);
          end else begin
            n.avg_cnt = q.avg_cnt + 11'h001;
            n.chan = next_chan(2'h0, mask);
            n.adc_start = 1'b1;
            n.tload = 1'b1;
            n.tload_us = chan_us(n.chan, q.setup);
            if (fin) begin
              n.avg_cnt = 11'h000;
              n.sum_sh = 32'h00000000;
              n.sum_bus = 32'h00000000;
              n.sum_tmp = 32'h00000000;
              n.done = 1'b1;
              if (shift != 4'h0) begin
                if (mask[`CHAN_SH]) begin
                  n.res_sh = avg_sh;
                  n.cur = b_cur;
                end
                if (mask[`CHAN_BUS]) begin
                  n.res_bus = avg_bus;
                  n.pwr = b_pwr;
                end
                if (mask[`CHAN_TMP]) begin
                  n.res_tmp = 32'($signed(fin_tmp) >>> shift);
                end
              end
              if (!cont) begin
                n.state = meter_pkg::seq_idle;
                n.adc_start = 1'b0;
                n.tload = 1'b0;
              end // otherwise loop again
            end
          end
        end
      end
      default: begin
      end
    endcase
    // a mode write aborts and restarts, after the start delay
    if (setup_wr) begin
      n.avg_cnt = 11'h000;
      n.sum_sh = 32'h00000000;
      n.sum_bus = 32'h00000000;
      n.sum_tmp = 32'h00000000;
      n.adc_start = 1'b0;
      n.chan = next_chan(2'h0, new_mask);
      if (new_mask == 3'h0) begin
        n.state = meter_pkg::seq_idle;
        n.tload = 1'b0;
      end else begin
        n.state = meter_pkg::seq_delay;
        n.tload = 1'b1;
        n.tload_us = 19'(q.cfg[`DLY_MSB:`DLY_LSB] *
                     `DELAY_STEP_US);
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.cfg <= `CFG_RST;
      q.setup <= `SETUP_RST;
      q.cal <= `CAL_RST;
      q.state <= meter_pkg::seq_idle;
      q.chan <= `CHAN_NONE;
    end else begin
      q <= n;
    end
  end

  // outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign adc_start = q.adc_start;
  assign adc_chan = q.chan;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_done_source: assert property (
    $rose(q.done) |-> $past(fin))
    else $error("done flag set without finished averaging");
  chk_done_read_clear: assert property (
    diag_rd && !fin |=> !q.done)
    else $error("done flag survived a flag read");
  chk_done_shutdown: assert property (
    setup_wr && new_mask == 3'h0 && q.done && !diag_rd |=> q.done)
    else $error("shutdown write cleared done flag");
  chk_zero_cal_pwr: assert property (
    end_conv && cal_zero && q.chan == `CHAN_BUS && shift == 4'h0
    && !setup_wr |=> q.pwr == 32'h00000000)
    else $error("power nonzero with zero calibration");
  chk_avg1_result: assert property (
    end_conv && q.chan == `CHAN_SH && shift == 4'h0 && !setup_wr
    |=> q.res_sh == $past(smp))
    else $error("shunt result not loaded at conversion end");
  chk_result_hold: assert property (
    !end_conv |=> $stable(q.res_sh) && $stable(q.res_bus))
    else $error("result changed without a conversion");
  chk_mode_restart: assert property (
    setup_wr && new_mask != 3'h0
    |=> q.state == meter_pkg::seq_delay && q.avg_cnt == 11'h000
    ##1 !adc_start)
    else $error("mode write did not restart");
  chk_trig_stop: assert property (
    fin && !cont |=> q.state == meter_pkg::seq_idle && !adc_start)
    else $error("triggered sequence did not stop");
  chk_cont_loop: assert property (
    fin && cont |=> q.state == meter_pkg::seq_conv && adc_start)
    else $error("continuous sequence did not repeat");
  chk_bvalid_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  cov_cont_done: cover property (fin && cont);
  cov_trig_done: cover property (fin && !cont);
  cov_avg_repeat: cover property (seq_end && !fin && shift != 4'h0);
  cov_flag_read: cover property (diag_rd && q.done);
endmodule // measurement_sequencer_calc_engine

// *** meter_cfg.svh ***
// Purpose: constants for the measurement sequencer
// Assumes: 20 MHz aclk, 1 MHz oscillator timebase
// Notes: definitions only
`ifndef METER_CFG_SVH
`define METER_CFG_SVH
// register byte offsets
`define REG_CFG 8'h00
`define REG_SETUP 8'h04
`define REG_CAL 8'h08
`define REG_DIAG 8'h0C
`define REG_SHUNT 8'h10
`define REG_BUS 8'h14
`define REG_TEMP 8'h18
`define REG_CUR 8'h1C
`define REG_PWR 8'h20
`define REG_ENERGY 8'h24
`define REG_CHARGE 8'h28
// writable bits and reset values
`define CFG_MASK 32'h00003FC0
`define SETUP_MASK 32'h0000FFFF
`define CAL_MASK 32'h0000FFFF
`define CFG_RST 32'h00000000
`define SETUP_RST 32'h00000000
`define CAL_RST 32'h00000000
// field positions
`define DLY_LSB 6
`define DLY_MSB 13
`define MASK_LSB 0
`define MASK_MSB 2
`define CONT_BIT 3
`define SH_CT_LSB 4
`define BUS_CT_LSB 7
`define TMP_CT_LSB 10
`define AVG_LSB 13
`define DIAG_VALID_BIT 0
`define DIAG_DONE_BIT 1
// conversion periods in microseconds
`define CT0_US 50
`define CT1_US 84
`define CT2_US 150
`define CT3_US 280
`define CT4_US 540
`define CT5_US 1052
`define CT6_US 2074
`define CT7_US 4120
// start delay step, 2 ms in microseconds
`define DELAY_STEP_US 2000
// timebase
`define OSC_PERIOD_NS 1000
`define CLK_PERIOD_NS 50
`define TICK_CYCLES (`OSC_PERIOD_NS / `CLK_PERIOD_NS)
// arithmetic scaling, bus answers and input channel codes
`define CUR_SHIFT 11
`define PWR_SHIFT 20
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CHAN_SH 2'h0
`define CHAN_BUS 2'h1
`define CHAN_TMP 2'h2
`define CHAN_NONE 2'h3
`endif

// *** meter_pkg.sv ***
// Purpose: types for the measurement sequencer
// Assumes: nothing
// Notes: state of the sequencer and of the timer is one packed struct each
package meter_pkg;
  // sequencer states
  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_delay = 2'b01,
    seq_conv = 2'b10
  } seq_state_t;

  // microsecond timer state
  typedef struct packed {
    logic busy;
    logic expired;
    logic [15:0] pre;
    logic [18:0] rem;
  } timer_state_t;

  // main block state
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic aw_full, w_full;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [31:0] cfg, setup, cal;
    seq_state_t state;
    logic [1:0] chan;
    logic [10:0] avg_cnt;
    logic [31:0] sum_sh, sum_bus, sum_tmp;
    logic [31:0] res_sh, res_bus, res_tmp;
    logic [31:0] cur, pwr, inst_cur;
    logic [31:0] energy, charge;
    logic done;
    logic adc_start;
    logic tload;
    logic [18:0] tload_us;
  } core_state_t;
endpackage

// *** calc_unit.sv ***
// Purpose: current and power arithmetic
// Assumes: signed samples, unsigned calibration scale
// Notes: purely combinational
`include "meter_cfg.svh"
module calc_unit (
  // operands
  input wire logic [31:0] shunt,
  input wire logic [31:0] cur_in,
  input wire logic [31:0] bus,
  input wire logic [15:0] cal,
  // results
  output logic [31:0] cur_out,
  output logic [31:0] pwr_out
);
  logic signed [63:0] cur_p;
  logic signed [63:0] pwr_p;
  logic signed [63:0] cal_s;

  // current from shunt, power from a given current and bus
  assign cal_s = 64'($signed({1'b0, cal}));
  assign cur_p = 64'($signed(shunt)) * cal_s;
  assign pwr_p = 64'($signed(cur_in)) * 64'($signed(bus));
  assign cur_out = 32'(cur_p >>> `CUR_SHIFT);
  assign pwr_out = (cal == 16'h0000) ? 32'h00000000
                 : 32'(pwr_p >>> `PWR_SHIFT);
endmodule // calc_unit

// *** tick_timer.sv ***
// Purpose: interval timer counted in oscillator microseconds
// Assumes: load is a one-cycle pulse
// Notes: expired pulses once when the interval ends
`include "meter_cfg.svh"
module tick_timer #(
  parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic load,
  input wire logic [18:0] load_us,
  output logic expired
);
  meter_pkg::timer_state_t t_q, t_d;

  // prescale to 1 us then count down
  always_comb begin
    t_d = t_q;
    t_d.expired = 1'b0;
    if (load) begin
      t_d.busy = 1'b1;
      t_d.rem = load_us;
      t_d.pre = 16'h0000;
    end else if (t_q.busy) begin
      if (t_q.rem == 19'h00000) begin
        t_d.busy = 1'b0;
        t_d.expired = 1'b1;
      end else if (t_q.pre == 16'(TICK_CYCLES - 1)) begin
        t_d.pre = 16'h0000;
        t_d.rem = t_q.rem - 19'h00001;
      end else begin
        t_d.pre = t_q.pre + 16'h0001;
      end
    end
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign expired = t_q.expired;
endmodule // tick_timer

// *** adc_model.sv ***
// Purpose: converter front end model
// Assumes: sample read while its input stays selected
// Notes: no input selected gives a toggling pattern
module adc_model (
  // clock and selection
  input wire logic aclk,
  input wire logic [1:0] adc_chan,
  // sample values per input
  input wire logic [19:0] sh_v,
  input wire logic [19:0] bus_v,
  input wire logic [19:0] tmp_v,
  // sample to the sequencer
  output logic [19:0] adc_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [19:0] junk_q = 20'h5A5A5;
  // idle pattern, never a stale sample
  always_ff @(posedge aclk) begin
    junk_q <= ~junk_q;
  end
  // sample follows the selected input
  always_comb begin
    case (adc_chan)
      2'h0: adc_data = sh_v;
      2'h1: adc_data = bus_v;
      2'h2: adc_data = tmp_v;
      default: adc_data = junk_q;
    endcase
  end
endmodule // adc_model

// *** measurement_sequencer_calc_engine_tb.sv ***
// Purpose: self-checking bench for the sequencer
// Assumes: TICK_CYCLES of 1, so 1 us is 1 cycle
// Notes: random samples from a fixed seed
`include "meter_cfg.svh"
module measurement_sequencer_calc_engine_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, adc_start;
  logic [1:0] bresp, rresp, adc_chan, rs;
  logic [31:0] rdata, rd;
  logic [19:0] adc_data;
  logic [19:0] sh_v = 20'h0, bus_v = 20'h0, tmp_v = 20'h0;
  int failures = 0;
  int n_tests = 0;
  int starts = 0;
  // 20 MHz clock
  always #25 aclk = ~aclk;
  // conversion starts seen at the front end
  always @(posedge aclk) begin
    if (adc_start === 1'b1) begin
      starts <= starts + 1;
    end
  end
  measurement_sequencer_calc_engine #(.TICK_CYCLES(1)) dut (.aclk,
    .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .adc_start, .adc_chan, .adc_data);
  adc_model fe (.aclk, .adc_chan, .sh_v, .bus_v, .tmp_v, .adc_data);
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // one bus write, both channels offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ak, wk;
    ak = 1'b0;
    wk = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ak && wk)) begin
      @(posedge aclk);
      if (!ak && awready === 1'b1) begin
        ak = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wk && wready === 1'b1) begin
        wk = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // one bus read
  task automatic rdr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_done();
    do rdr(`REG_DIAG); while (rd[`DIAG_DONE_BIT] !== 1'b1);
  endtask
  function automatic logic [31:0] sx(input logic [19:0] v);
    return {{12{v[19]}}, v};
  endfunction
  function automatic logic [31:0] fcur(input logic [19:0] s,
    input logic [15:0] c);
    logic signed [63:0] p;
    p = $signed(sx(s)) * $signed({1'b0, c});
    p = p >>> 11;
    return p[31:0];
  endfunction
  function automatic logic [31:0] fpwr(input logic [31:0] cu,
    input logic [19:0] b);
    logic signed [63:0] p;
    p = $signed(cu) * $signed(sx(b));
    p = p >>> 20;
    return p[31:0];
  endfunction
  // one triggered run of na sequences on all inputs, then result checks
  task automatic run(input logic [2:0] sct, input logic [2:0] avg);
    logic [19:0] s, b, t;
    logic [15:0] c;
    logic [31:0] cu, e0, q0;
    int na, st0;
    s = 20'($urandom_range(32'h7FFF)) - 20'h04000;
    b = 20'($urandom_range(32'h07FF));
    t = 20'($urandom_range(32'hFFFF)) - 20'h08000;
    c = 16'($urandom_range(32'hFFFF)) | 16'h0001;
    cu = fcur(s, c);
    sh_v <= s;
    bus_v <= b;
    tmp_v <= t;
    // averaging codes 0 to 3 stand for 4 to the power of the code
    na = 1 << (2 * avg);
    wr(`REG_CAL, {16'h0000, c});
    rdr(`REG_ENERGY);
    e0 = rd;
    rdr(`REG_CHARGE);
    q0 = rd;
    st0 = starts;
    wr(`REG_SETUP, {16'h0000, avg, 6'h00, sct, 4'h7});
    wait_done();
    rdr(`REG_SHUNT);
    chk("shunt", rd, sx(s));
    rdr(`REG_BUS);
    chk("bus", rd, sx(b));
    rdr(`REG_TEMP);
    chk("temp", rd, sx(t));
    rdr(`REG_CUR);
    chk("current", rd, cu);
    rdr(`REG_PWR);
    chk("power", rd, fpwr(cu, b));
    rdr(`REG_ENERGY);
    chk("energy", rd - e0, 32'(na) * fpwr(cu, b));
    rdr(`REG_CHARGE);
    chk("charge", rd - q0, 32'(na) * cu);
    chk("starts", 32'(starts - st0), 32'(3 * na));
    rdr(`REG_DIAG);
    chk("flags", rd, 32'h0);
  endtask
  // main sequence
  initial begin
    logic [31:0] wv;
    void'($urandom(32'hA64C));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 3; i++) begin
      rdr(8'(4 * i));
      chk("reset value", rd, 32'h0);
    end
    rdr(8'h30);
    chk("unmapped resp", 32'(rs), 32'(`RESP_SLVERR));
    wr(`REG_DIAG, 32'hFFFFFFFF);
    chk("read-only resp", 32'(rs), 32'(`RESP_SLVERR));
    wv = $urandom();
    wr(`REG_CFG, wv);
    rdr(`REG_CFG);
    chk("cfg", rd, wv & `CFG_MASK);
    // back to no start delay so that the runs stay short
    wr(`REG_CFG, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      run(3'(i), 3'h0);
    end
    run(3'h0, 3'h1);
    run(3'h0, 3'h2);
    $display("test triggered runs done");
    wr(`REG_CFG, 32'h00000040);
    wr(`REG_SETUP, 32'h00000001);
    repeat (1900) @(posedge aclk);
    rdr(`REG_DIAG);
    chk("delayed done", 32'(rd[`DIAG_DONE_BIT]), 32'h0);
    wait_done();
    wr(`REG_CFG, 32'h0);
    $display("test start delay done");
    wr(`REG_SETUP, 32'h0000000B);
    repeat (300) @(posedge aclk);
    rdr(`REG_DIAG);
    chk("cont flags", rd, 32'h3);
    repeat (300) @(posedge aclk);
    rdr(`REG_DIAG);
    chk("cont again", 32'(rd[`DIAG_DONE_BIT]), 32'h1);
    repeat (300) @(posedge aclk);
    wr(`REG_SETUP, 32'h0000000B);
    rdr(`REG_DIAG);
    chk("write clears", 32'(rd[`DIAG_DONE_BIT]), 32'h0);
    repeat (300) @(posedge aclk);
    wr(`REG_SETUP, 32'h0);
    rdr(`REG_DIAG);
    chk("shutdown keeps", 32'(rd[`DIAG_DONE_BIT]), 32'h1);
    $display("test continuous done");
    wr(`REG_CAL, 32'h0);
    wr(`REG_SETUP, 32'h00000003);
    wait_done();
    for (int i = 0; i < 3; i++) begin
      rdr(8'(`REG_PWR + 4 * i));
      chk("zero scale", rd, 32'h0);
    end
    $display("test zero scale done");
    print_verdict();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (60000) @(posedge aclk);
    failures++;
    print_verdict();
  end
endmodule // measurement_sequencer_calc_engine_tb
